// File: rtl/cdb_device_ctrl.sv
// Device-control register bank with AHB-Lite slave, timestamp, locate and pacing
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`include "cdb_defines.svh"
//
// Summary of operation
// - Limit mode off lets packets pass freely; on applies the programmed cap.
// - Cap streamed bytes per second by spacing packet grants uniformly.
// - Latch command copies the running timestamp into the readable snapshot.
// - Reset command resets the bank and its outputs, except the uptime count and its seconds divider.
// - Locate command inverts the red indicator once, then restores it.
// - Temperature readout follows the component chosen by the selector.
// - User label is writable and reads as zero until written.
// - Uptime counts whole seconds since power-up.
// - Speed readout tells high speed from superspeed.
// - Identification values and stream channel count are readable.
// - Current throughput reports bytes actually granted in the last second.
module cdb_device_ctrl
    import cdb_pkg::*;
#(
    parameter int unsigned SEC_CYCLES   = `CDB_CLK_HZ,
    parameter int unsigned BLINK_CYCLES = `CDB_BLINK_MS * (`CDB_CLK_HZ / 1000)
) (
    input  wire logic        CLOCK,           // 100 MHz clock
    input  wire logic        RESET,           // Synchronous reset, high
    input  wire logic        HSEL,            // Slave select
    input  wire logic [31:0] HADDR,           // Address
    input  wire logic [1:0]  HTRANS,          // Transfer type
    input  wire logic        HWRITE,          // Write
    input  wire logic [2:0]  HSIZE,           // Transfer size
    input  wire logic [31:0] HWDATA,          // Write data
    input  wire logic        HREADY,          // Bus ready
    output logic             HREADYOUT,       // Slave ready
    output logic             HRESP,           // Always OKAY
    output logic [31:0]      HRDATA,          // Read data
    input  wire logic        PKT_REQ,         // Packet waiting to send
    input  wire logic [15:0] PKT_BYTES,       // Packet length in bytes
    output logic             PKT_GRANT,       // Packet may go
    input  wire logic [15:0] TEMP_SENSOR,     // Sensor temperature
    input  wire logic [15:0] TEMP_BOARD,      // Board temperature
    input  wire logic        LINK_SUPERSPEED, // Pin: link at superspeed
    input  wire logic        LED_RED_IDLE,    // Normal indicator level
    output logic             LED_RED,         // Red indicator
    output logic             DEVICE_RESET     // Full reset pulse
);

    // ****************************************
    // Reset and bus address phase
    // ****************************************
    logic        soft_rst;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr_q;
    wire         sys_rst = RESET || soft_rst;
    wire         acc     = HSEL && HTRANS[1] && HREADY && (HSIZE == `CDB_HSIZE_WORD);

    // Reads take one wait state so a preceding write is always visible
    always_ff @(posedge CLOCK) begin
        if (sys_rst) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            addr_q    <= 8'h0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            wr_pend   <= acc && HWRITE;
            rd_pend   <= acc && !HWRITE;
            HREADYOUT <= !(acc && !HWRITE);
            if (acc) begin
                addr_q <= HADDR[7:0];
            end
        end
    end

    // ****************************************
    // Write decode
    // ****************************************
    wire wr_cmd  = wr_pend && (addr_q == `CDB_OFF_CMD);
    wire do_lat  = wr_cmd && HWDATA[`CDB_CMD_LATCH];
    wire do_rst  = wr_cmd && HWDATA[`CDB_CMD_RESET];
    wire do_loc  = wr_cmd && HWDATA[`CDB_CMD_LOCATE];
    wire wr_tsel = wr_pend && (addr_q == `CDB_OFF_TEMP_SEL);
    wire wr_mode = wr_pend && (addr_q == `CDB_OFF_LIM_MODE);
    wire wr_rate = wr_pend && (addr_q == `CDB_OFF_LIM_RATE);
    wire wr_lab  = wr_pend && (addr_q >= `CDB_OFF_LABEL0) && (addr_q <= `CDB_OFF_LABEL3);
    wire [7:0] lab_off = addr_q - `CDB_OFF_LABEL0;
    wire [1:0] lab_idx = lab_off[3:2];

    // Reset command pulses for one cycle and clears the bank, except uptime and the seconds divider
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= do_rst && !soft_rst;
        end
    end
    assign DEVICE_RESET = soft_rst;

    // ****************************************
    // Host-written settings
    // ****************************************
    cdb_word_t   label [4];
    logic        temp_sel;
    logic        lim_mode;
    logic [31:0] lim_rate;

    // Settings; read-only offsets have no write path
    always_ff @(posedge CLOCK) begin
        if (sys_rst) begin
            label    <= '{default: 32'h0};
            temp_sel <= 1'b0;
            lim_mode <= 1'b0;
            lim_rate <= `CDB_LIM_RATE_RST;
        end else begin
            if (wr_lab) begin
                label[lab_idx] <= HWDATA;
            end
            if (wr_tsel) begin
                temp_sel <= HWDATA[0];
            end
            if (wr_mode) begin
                lim_mode <= HWDATA[0];
            end
            if (wr_rate) begin
                lim_rate <= HWDATA;
            end
        end
    end

    // ****************************************
    // Timestamp, uptime and temperature
    // ****************************************
    logic [63:0] ts_count;
    logic [63:0] ts_snap;
    logic [31:0] uptime;
    logic [15:0] temp_q;
    logic        sec_tick;

    cdb_tick_div #(.CYCLES(SEC_CYCLES)) u_sec (
        .clk  (CLOCK),
        .rst  (RESET),
        .tick (sec_tick)
    );

    // Running timestamp in clock periods, snapshot on latch
    always_ff @(posedge CLOCK) begin
        if (sys_rst) begin
            ts_count <= 64'h0;
            ts_snap  <= 64'h0;
            temp_q   <= 16'h0;
        end else begin
            ts_count <= ts_count + 64'h1;
            temp_q   <= temp_sel ? TEMP_BOARD : TEMP_SENSOR;
            if (do_lat) begin
                ts_snap <= ts_count;
            end
        end
    end

    // Uptime survives the reset command, only power-on clears it
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            uptime <= 32'h0;
        end else if (sec_tick) begin
            uptime <= uptime + 32'h1;
        end
    end

    // ****************************************
    // Link speed pin synchroniser
    // ****************************************
    logic       spd_m;
    logic       spd_s;
    cdb_speed_e speed;

    // Two flops, then the readout register
    always_ff @(posedge CLOCK) begin
        if (sys_rst) begin
            spd_m <= 1'b0;
            spd_s <= 1'b0;
            speed <= CDB_SPD_HIGH;
        end else begin
            spd_m <= LINK_SUPERSPEED;
            spd_s <= spd_m;
            speed <= spd_s ? CDB_SPD_SUPER : CDB_SPD_HIGH;
        end
    end

    // ****************************************
    // Locate indicator
    // ****************************************
    cdb_loc_e    loc_state;
    logic [31:0] blink_cnt;
    wire         blink_end = (blink_cnt == 32'(BLINK_CYCLES - 1));

    // One inversion of the normal level; repeats during a blink are ignored
    always_ff @(posedge CLOCK) begin
        if (sys_rst) begin
            loc_state <= CDB_LOC_IDLE;
            blink_cnt <= 32'h0;
            LED_RED   <= 1'b0;
        end else begin
            LED_RED <= (loc_state == CDB_LOC_BLINK) ? !LED_RED_IDLE : LED_RED_IDLE;
            unique case (loc_state)
                CDB_LOC_IDLE: begin
                    blink_cnt <= 32'h0;
                    if (do_loc) begin
                        loc_state <= CDB_LOC_BLINK;
                    end
                end
                CDB_LOC_BLINK: begin
                    blink_cnt <= blink_cnt + 32'h1;
                    if (blink_end) begin
                        loc_state <= CDB_LOC_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Throughput limiter and measurement
    // ****************************************
    logic [31:0] bytes_acc;
    logic [31:0] cur_tp;
    wire  [31:0] add = PKT_GRANT ? 32'(PKT_BYTES) : 32'h0;

    cdb_rate_limiter u_lim (
        .clk   (CLOCK),
        .rst   (sys_rst),
        .en    (lim_mode),
        .rate  (lim_rate),
        .req   (PKT_REQ),
        .bytes (PKT_BYTES),
        .grant (PKT_GRANT)
    );

    // Bytes granted over each one-second window
    always_ff @(posedge CLOCK) begin
        if (sys_rst) begin
            bytes_acc <= 32'h0;
            cur_tp    <= 32'h0;
        end else if (sec_tick) begin
            cur_tp    <= bytes_acc + add;
            bytes_acc <= 32'h0;
        end else begin
            bytes_acc <= bytes_acc + add;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    function automatic cdb_word_t rd_sel(input logic [7:0] a);
        unique case (a)
            `CDB_OFF_VENDOR:    rd_sel = `CDB_VENDOR_VAL;
            `CDB_OFF_MODEL:     rd_sel = `CDB_MODEL_VAL;
            `CDB_OFF_HW_VER:    rd_sel = `CDB_HW_VER_VAL;
            `CDB_OFF_FW_VER:    rd_sel = `CDB_FW_VER_VAL;
            `CDB_OFF_SERIAL:    rd_sel = `CDB_SERIAL_VAL;
            `CDB_OFF_CHANNELS:  rd_sel = `CDB_CHANNELS_VAL;
            `CDB_OFF_LABEL0:    rd_sel = label[0];
            `CDB_OFF_LABEL1:    rd_sel = label[1];
            `CDB_OFF_LABEL2:    rd_sel = label[2];
            `CDB_OFF_LABEL3:    rd_sel = label[3];
            `CDB_OFF_TS_LO:     rd_sel = ts_snap[31:0];
            `CDB_OFF_TS_HI:     rd_sel = ts_snap[63:32];
            `CDB_OFF_UPTIME:    rd_sel = uptime;
            `CDB_OFF_TEMP_SEL:  rd_sel = {31'h0, temp_sel};
            `CDB_OFF_TEMP:      rd_sel = {16'h0, temp_q};
            `CDB_OFF_SPEED:     rd_sel = {31'h0, speed};
            `CDB_OFF_LIM_MODE:  rd_sel = {31'h0, lim_mode};
            `CDB_OFF_LIM_RATE:  rd_sel = lim_rate;
            `CDB_OFF_CUR_TP:    rd_sel = cur_tp;
            `CDB_OFF_RESP_TIME: rd_sel = `CDB_RESP_MS_VAL;
            default:            rd_sel = 32'h0;
        endcase
    endfunction : rd_sel

    cdb_word_t rd_word;

    // Process form so the mux follows every register it reads
    always_comb begin
        rd_word = rd_sel(addr_q);
    end

    // Read data loaded in the wait cycle
    always_ff @(posedge CLOCK) begin
        if (sys_rst) begin
            HRDATA <= 32'h0;
        end else if (rd_pend) begin
            HRDATA <= rd_word;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    property p_mode_bypass;
        !lim_mode && PKT_REQ && !PKT_GRANT && !soft_rst |=> PKT_GRANT;
    endproperty
    a_mode_bypass: assert property (p_mode_bypass) else $error("limit off but packet held");

    property p_latch;
        do_lat && !soft_rst |=> ts_snap == $past(ts_count);
    endproperty
    a_latch: assert property (p_latch) else $error("timestamp snapshot wrong");

    property p_reset;
        do_rst && !soft_rst |=> DEVICE_RESET ##1 (!DEVICE_RESET && label[0] == 32'h0);
    endproperty
    a_reset: assert property (p_reset) else $error("reset command not one pulse");

    sequence s_loc_start;
        do_loc && !soft_rst && loc_state == CDB_LOC_IDLE;
    endsequence
    property p_locate;
        s_loc_start |=> loc_state == CDB_LOC_BLINK ##1 LED_RED != $past(LED_RED_IDLE);
    endproperty
    a_locate: assert property (p_locate) else $error("locate did not invert indicator");

    property p_locate_end;
        loc_state == CDB_LOC_BLINK && blink_end && !soft_rst |=> ##1 LED_RED == $past(LED_RED_IDLE);
    endproperty
    a_locate_end: assert property (p_locate_end) else $error("indicator not restored");

    property p_temp;
        !temp_sel && !soft_rst ##1 !soft_rst |-> temp_q == $past(TEMP_SENSOR);
    endproperty
    a_temp: assert property (p_temp) else $error("temperature not from selected part");

    property p_label_rst;
        soft_rst |=> label[0] == 32'h0 && label[3] == 32'h0;
    endproperty
    a_label_rst: assert property (p_label_rst) else $error("label not empty after reset");

    property p_uptime;
        sec_tick |=> uptime == $past(uptime) + 32'h1;
    endproperty
    a_uptime: assert property (p_uptime) else $error("uptime did not advance");

    property p_speed;
        (LINK_SUPERSPEED && !sys_rst) [*4] |-> speed == CDB_SPD_SUPER;
    endproperty
    a_speed: assert property (p_speed) else $error("speed readout not superspeed");

    property p_tp;
        sec_tick && !sys_rst |=> cur_tp == $past(bytes_acc) + $past(add);
    endproperty
    a_tp: assert property (p_tp) else $error("throughput window wrong");

endmodule : cdb_device_ctrl

// File: rtl/cdb_defines.svh
// Register offsets, field positions, reset values and timing counts of the device-control bank
`ifndef CDB_DEFINES_SVH
`define CDB_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CDB_OFF_VENDOR    8'h00
`define CDB_OFF_MODEL     8'h04
`define CDB_OFF_HW_VER    8'h08
`define CDB_OFF_FW_VER    8'h0c
`define CDB_OFF_SERIAL    8'h10
`define CDB_OFF_CHANNELS  8'h14
`define CDB_OFF_LABEL0    8'h18
`define CDB_OFF_LABEL1    8'h1c
`define CDB_OFF_LABEL2    8'h20
`define CDB_OFF_LABEL3    8'h24
`define CDB_OFF_TS_LO     8'h28
`define CDB_OFF_TS_HI     8'h2c
`define CDB_OFF_CMD       8'h30
`define CDB_OFF_UPTIME    8'h34
`define CDB_OFF_TEMP_SEL  8'h38
`define CDB_OFF_TEMP      8'h3c
`define CDB_OFF_SPEED     8'h40
`define CDB_OFF_LIM_MODE  8'h44
`define CDB_OFF_LIM_RATE  8'h48
`define CDB_OFF_CUR_TP    8'h4c
`define CDB_OFF_RESP_TIME 8'h50

// ****************************************
// Command register bit positions
// ****************************************
`define CDB_CMD_LATCH  0
`define CDB_CMD_RESET  1
`define CDB_CMD_LOCATE 2

// ****************************************
// Read-only values, reset values and bus size code
// ****************************************
`define CDB_VENDOR_VAL   32'h00c0ffee
`define CDB_MODEL_VAL    32'h00000a11
`define CDB_HW_VER_VAL   32'h00010000
`define CDB_FW_VER_VAL   32'h00010000
`define CDB_SERIAL_VAL   32'h12345678
`define CDB_CHANNELS_VAL 32'h00000001
`define CDB_RESP_MS_VAL  32'h000000c8
`define CDB_LIM_RATE_RST 32'h17d78400
`define CDB_HSIZE_WORD   3'h2

// ****************************************
// Timing
// ****************************************
`define CDB_CLK_HZ   100000000
`define CDB_BLINK_MS 200

`endif

// File: rtl/cdb_pkg.sv
// Types shared by the device-control bank
package cdb_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [31:0] cdb_word_t;

    typedef enum logic {
        CDB_SPD_HIGH  = 1'b0,
        CDB_SPD_SUPER = 1'b1
    } cdb_speed_e;

    typedef enum logic {
        CDB_LOC_IDLE  = 1'b0,
        CDB_LOC_BLINK = 1'b1
    } cdb_loc_e;

endpackage : cdb_pkg

// File: rtl/cdb_tick_div.sv
// Divider producing a one-cycle enable pulse every CYCLES clocks
module cdb_tick_div #(
    parameter int unsigned CYCLES = 100
) (
    input  wire logic clk,  // Clock
    input  wire logic rst,  // Synchronous reset
    output logic      tick  // One-cycle pulse
);

    logic [31:0] cnt;

    // Free-running count, pulse on wrap
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end else if (cnt == 32'(CYCLES - 1)) begin
            cnt  <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end

endmodule : cdb_tick_div

// File: rtl/cdb_rate_limiter.sv
// Packet pacing: grants packets so the byte rate stays under the cap
`include "cdb_defines.svh"
module cdb_rate_limiter
    import cdb_pkg::*;
(
    input  wire logic        clk,       // Clock
    input  wire logic        rst,       // Synchronous reset
    input  wire logic        en,        // Limit active
    input  wire logic [31:0] rate,      // Cap in bytes per second
    input  wire logic        req,       // Packet waiting
    input  wire logic [15:0] bytes,     // Packet length
    output logic             grant      // One-cycle grant pulse
);

    // Credit is in byte-cycles: rate added per clock, length*clock_hz per packet
    logic [47:0] credit;
    logic [47:0] cap;
    wire  [47:0] cost    = 48'(bytes) * 48'(`CDB_CLK_HZ);
    wire  [47:0] acc     = credit + 48'(rate);
    wire  [47:0] lim     = req ? cost : cap;
    wire         ok      = !en || (credit >= cost);
    wire         take    = req && !grant && ok;

    // Credit saturates at one packet (last real length when idle); cleared while off
    always_ff @(posedge clk) begin
        if (rst) begin
            credit <= 48'h0;
            cap    <= 48'h0;
            grant  <= 1'b0;
        end else begin
            grant <= take;
            if (req) begin
                cap <= cost;
            end
            if (!en) begin
                credit <= 48'h0;
            end else if (take) begin
                credit <= acc - cost;
            end else begin
                credit <= (acc > lim) ? lim : acc;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_bypass;
        !en && req && !grant |=> grant;
    endproperty
    a_bypass: assert property (p_bypass) else $error("unlimited packet not granted");

    property p_pace;
        en && req && !grant && (credit < cost) |=> !grant;
    endproperty
    a_pace: assert property (p_pace) else $error("packet granted without credit");

endmodule : cdb_rate_limiter

// File: verif/cdb_pkt_src.sv
// Packet source model that feeds the pacing port
module cdb_pkt_src (
    input  wire logic        clk,       // Clock
    input  wire logic        rst,       // Reset
    input  wire logic        load,      // Queue packets
    input  wire logic [3:0]  count,     // Packets queued
    input  wire logic [15:0] len,       // Packet length
    input  wire logic        pkt_grant, // Grant seen
    output logic             pkt_req,   // Packet waiting
    output logic [15:0]      pkt_bytes, // Length, junk idle
    output logic [15:0]      gap,       // Last grant spacing
    output logic [15:0]      prev_gap,  // Spacing before
    output logic [7:0]       n_grant    // Grants seen
);
    logic [3:0]  left;
    logic [15:0] cyc;
    logic [15:0] last;

    // ****************************************
    // Length is junk outside a request
    // ****************************************
    assign pkt_bytes = pkt_req ? len : ~len;

    // Hold until grant, drop one cycle, then next
    always_ff @(posedge clk) begin
        if (rst) begin
            pkt_req  <= 1'b0;
            left     <= 4'h0;
            cyc      <= 16'h0;
            last     <= 16'h0;
            gap      <= 16'h0;
            prev_gap <= 16'h0;
            n_grant  <= 8'h0;
        end else begin
            cyc <= cyc + 16'h1;
            if (pkt_grant) begin
                pkt_req  <= 1'b0;
                left     <= left - 4'h1;
                gap      <= cyc - last;
                prev_gap <= gap;
                last     <= cyc;
                n_grant  <= n_grant + 8'h1;
            end else if (load) begin
                left <= count;
            end else if (left != 4'h0) begin
                pkt_req <= 1'b1;
            end
        end
    end
endmodule : cdb_pkt_src

// File: verif/camera_device_control_bank_tb_top.sv
// Testbench for the device-control bank
`include "cdb_defines.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module camera_device_control_bank_tb_top
    import cdb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        CLOCK = 1'b0;
    logic        RESET = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, pkt_req, pkt_grant, led_red, dev_rst;
    logic [31:0] hrdata;
    logic [15:0] pkt_bytes, gap, prev_gap;
    logic [15:0] t_sens = 16'h1234;
    logic [15:0] t_brd = 16'h0567;
    logic        link_ss = 1'b0;
    logic        led_idle = 1'b1;
    logic        src_load = 1'b0;
    logic [7:0]  n_grant;
    logic [7:0]  ng;
    cdb_word_t   d, a, b;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cnt;
    logic [7:0]  ro_off [7] = '{`CDB_OFF_VENDOR, `CDB_OFF_MODEL, `CDB_OFF_HW_VER, `CDB_OFF_FW_VER,
                                `CDB_OFF_SERIAL, `CDB_OFF_CHANNELS, `CDB_OFF_RESP_TIME};
    cdb_word_t   ro_val [7] = '{`CDB_VENDOR_VAL, `CDB_MODEL_VAL, `CDB_HW_VER_VAL, `CDB_FW_VER_VAL,
                                `CDB_SERIAL_VAL, `CDB_CHANNELS_VAL, `CDB_RESP_MS_VAL};
    logic [7:0]  rv_off [8] = '{`CDB_OFF_LABEL0, `CDB_OFF_LABEL1, `CDB_OFF_LABEL2, `CDB_OFF_LABEL3,
                                `CDB_OFF_LIM_MODE, `CDB_OFF_LIM_RATE, `CDB_OFF_CMD, 8'h7c};
    cdb_word_t   rv_val [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, `CDB_LIM_RATE_RST, 32'h0, 32'h0};

    // ****************************************
    // Clock, design and packet source
    // ****************************************
    always #5 CLOCK = ~CLOCK;

    cdb_device_ctrl #(.SEC_CYCLES(20), .BLINK_CYCLES(5)) cdb_device_ctrl_inst (
        .CLOCK(CLOCK), .RESET(RESET), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .PKT_REQ(pkt_req),
        .PKT_BYTES(pkt_bytes), .PKT_GRANT(pkt_grant), .TEMP_SENSOR(t_sens), .TEMP_BOARD(t_brd),
        .LINK_SUPERSPEED(link_ss), .LED_RED_IDLE(led_idle), .LED_RED(led_red), .DEVICE_RESET(dev_rst));

    cdb_pkt_src cdb_pkt_src_inst (
        .clk(CLOCK), .rst(RESET), .load(src_load), .count(4'h3), .len(16'h4),
        .pkt_grant(pkt_grant), .pkt_req(pkt_req), .pkt_bytes(pkt_bytes), .gap(gap),
        .prev_gap(prev_gap), .n_grant(n_grant));

    // ****************************************
    // Bus, packet and finish tasks
    // ****************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // Bounded wait for ready, like a host giving up
    task automatic wait_rdy;
        for (int i = 0; i < 200; i++) begin
            @(posedge CLOCK);
            if (hreadyout === 1'b1) return;
        end
        error_cnt++;
        $display("[ERR] hready exp 1 got timeout");
        finish_test();
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [7:0] ad, input cdb_word_t v, output cdb_word_t r);
        @(posedge CLOCK);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ad};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= `CDB_HSIZE_WORD;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= v;
        wait_rdy();
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] ad, input cdb_word_t v);
        cdb_word_t r;
        bus(1'b1, ad, v, r);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] ad, input cdb_word_t ex);
        bus(1'b0, ad, 32'h0, d);
        `CHK(nm, ex, d)
    endtask : rd_chk

    task automatic pkts(input int n);
        @(posedge CLOCK);
        src_load <= 1'b1;
        @(posedge CLOCK);
        src_load <= 1'b0;
        repeat (n) @(posedge CLOCK);
    endtask : pkts

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge CLOCK);
        RESET <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            wr(ro_off[i], ~ro_val[i]);
            rd_chk("ro_reg", ro_off[i], ro_val[i]);
        end
        for (int i = 0; i < 8; i++) rd_chk("reset_val", rv_off[i], rv_val[i]);
        `CHK("hresp", 1'b0, hresp)
        $display("test identity done");
        wr(`CDB_OFF_LABEL3, 32'ha5a5_0f0f);
        rd_chk("label", `CDB_OFF_LABEL3, 32'ha5a5_0f0f);
        wr(`CDB_OFF_TEMP_SEL, 32'h0);
        rd_chk("temp_s", `CDB_OFF_TEMP, 32'h1234);
        wr(`CDB_OFF_TEMP_SEL, 32'h1);
        rd_chk("temp_b", `CDB_OFF_TEMP, 32'h0567);
        rd_chk("speed_hs", `CDB_OFF_SPEED, 32'h0);
        link_ss <= 1'b1;
        repeat (4) @(posedge CLOCK);
        rd_chk("speed_ss", `CDB_OFF_SPEED, 32'h1);
        $display("test readouts done");
        wr(`CDB_OFF_CMD, 32'h1);
        bus(1'b0, `CDB_OFF_TS_LO, 32'h0, a);
        repeat (10) @(posedge CLOCK);
        rd_chk("ts_hold", `CDB_OFF_TS_LO, a);
        rd_chk("ts_hi", `CDB_OFF_TS_HI, 32'h0);
        wr(`CDB_OFF_CMD, 32'h1);
        bus(1'b0, `CDB_OFF_TS_LO, 32'h0, b);
        `CHK("ts_adv", 1'b1, b > a)
        bus(1'b0, `CDB_OFF_UPTIME, 32'h0, a);
        repeat (37) @(posedge CLOCK);
        bus(1'b0, `CDB_OFF_UPTIME, 32'h0, b);
        `CHK("uptime", 1'b1, (b - a) >= 2 && (b - a) <= 3)
        $display("test time done");
        wr(`CDB_OFF_CMD, 32'h4);
        cnt = 0;
        for (int i = 0; i < 30; i++) begin
            @(posedge CLOCK);
            if (led_red === 1'b0) cnt++;
        end
        `CHK("blink_len", 5, cnt)
        `CHK("led_back", 1'b1, led_red)
        $display("test locate done");
        wr(`CDB_OFF_LIM_RATE, 32'h0);
        wr(`CDB_OFF_LIM_MODE, 32'h1);
        ng = n_grant;
        pkts(50);
        `CHK("rate0", ng, n_grant)
        wr(`CDB_OFF_LIM_RATE, 32'h05f5e100);
        repeat (60) @(posedge CLOCK);
        pkts(60);
        `CHK("lim_cnt", ng + 8'h6, n_grant)
        `CHK("lim_gap", 1'b1, gap >= 16'h4)
        `CHK("uniform", gap, prev_gap)
        wr(`CDB_OFF_LIM_MODE, 32'h0);
        pkts(30);
        `CHK("free_gap", 1'b1, gap <= 16'h3)
        $display("test pacing done");
        bus(1'b0, `CDB_OFF_UPTIME, 32'h0, a);
        wr(`CDB_OFF_LIM_MODE, 32'h1);
        wr(`CDB_OFF_CMD, 32'h2);
        cnt = 0;
        for (int i = 0; i < 10; i++) begin
            @(posedge CLOCK);
            if (dev_rst === 1'b1) cnt++;
        end
        `CHK("reset_pulse", 1, cnt)
        rd_chk("label_clr", `CDB_OFF_LABEL3, 32'h0);
        rd_chk("mode_clr", `CDB_OFF_LIM_MODE, 32'h0);
        rd_chk("tp_clr", `CDB_OFF_CUR_TP, 32'h0);
        bus(1'b0, `CDB_OFF_UPTIME, 32'h0, b);
        `CHK("uptime_kept", 1'b1, b >= a)
        $display("test reset done");
        finish_test();
    end
endmodule : camera_device_control_bank_tb_top
